//--- hw/spr_buf2.v
// two-entry valid/ready buffer for received words
`timescale 1ns/1ns
`default_nettype none

module spr_buf2 #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         ce,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);

    reg [W-1:0] mem_q [0:1];
    reg         wp_q;
    reg         rp_q;
    reg [1:0]   cnt_q;
    wire        push;
    wire        pop;

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rp_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end
        else if (ce)
        begin
            if (push)
            begin
                mem_q[wp_q] <= in_data;
                wp_q        <= ~wp_q;
            end
            if (pop)
                rp_q <= ~rp_q;
            if (push & ~pop)
                cnt_q <= cnt_q + 2'h1;
            else if (pop & ~push)
                cnt_q <= cnt_q - 2'h1;
        end
    end

endmodule // spr_buf2

`default_nettype wire

//--- hw/spr_core.v
// serial port with programmable master clock rate and synchronised slave engine
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "spr_map.vh"

// Overview of operation
// RULE_01: master clock period is two times (divider plus one) core clocks, divider 0..255.
// RULE_02: polarity select one inverts the serial clock, including its idle level.
// RULE_03: external master lowers select two core clocks before first serial edge.
// RULE_04: external master waits two core clocks after last edge before raising select.
// RULE_05: slave output valid within four core clocks after select falls.
// RULE_06: slave output released within four core clocks after select rises.
// RULE_07: external serial clock phases last at least five core clocks each.
// RULE_08: external data stable two core clocks around each sampling edge.
// RULE_09: slave output updates within four core clocks after each shifting edge.
// RULE_10: phase one slave output changes six to eight clocks after final edge.
// RULE_11: serial clock, select and data inputs are synchronised before edge detection.
module spr_core #(
    parameter DW = 8
) (
    input  wire                   SYS_CLK,
    input  wire                   RST_N,
    input  wire                   CE,
    input  wire [`SPR_ADDR_W-1:0] ADDR,
    input  wire [7:0]             WDATA,
    input  wire                   WR,
    input  wire                   RD,
    output reg  [7:0]             RDATA,
    input  wire                   SCK_I,
    output reg                    SCK_O,
    output reg                    SCK_OE,
    input  wire                   MOSI_I,
    output reg                    MOSI_O,
    output reg                    MOSI_OE,
    input  wire                   MISO_I,
    output reg                    MISO_O,
    output reg                    MISO_OE,
    input  wire                   SEL_N_I
);

    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;
    localparam [2:0] LAST_WAIT = `SPR_LAST_WAIT;

    reg  [7:0]    div_q;
    reg  [3:0]    ctl_q;
    reg  [DW-1:0] tx_q;
    reg           tx_full_q;
    reg           ovr_q;
    reg           st_q;
    reg  [7:0]    hc_q;
    reg  [3:0]    ec_q;
    reg  [DW-1:0] sh_q;
    reg  [DW-1:0] rx_q;
    reg  [2:0]    lh_q;
    reg           lh_on_q;
    reg  [3:0]    s1_q;
    reg  [3:0]    s2_q;
    reg           sck_d_q;
    reg           sel_d_q;

    wire          en       = ctl_q[`SPR_CTL_ENABLE];
    wire          master   = ctl_q[`SPR_CTL_MASTER];
    wire          cpol     = ctl_q[`SPR_CTL_POLARITY];
    wire          cpha     = ctl_q[`SPR_CTL_PHASE];
    wire          sck_s    = s2_q[0];
    wire          sel_n_s  = s2_q[1];
    wire          mosi_s   = s2_q[2];
    wire          miso_s   = s2_q[3];
    wire          slave_on = en & ~master;
    wire          sel_fall = slave_on & sel_d_q & ~sel_n_s;
    wire          sck_edge = slave_on & ~sel_n_s & (sck_s != sck_d_q);
    wire          m_tick   = master & (st_q == ST_RUN) & (hc_q == div_q);
    wire          edge_now = m_tick | sck_edge;
    wire          lead     = ~ec_q[0];
    wire          sample   = edge_now & (lead ^ cpha);
    wire          shift    = edge_now & ~(lead ^ cpha);
    wire          last     = edge_now & (ec_q == `SPR_LAST_EDGE);
    wire          in_bit   = master ? miso_s : mosi_s;
    wire [DW-1:0] rx_nx    = sample ? {rx_q[DW-2:0], in_bit} : rx_q;
    wire          buf_ready;
    wire          rx_valid;
    wire [DW-1:0] rx_data;
    wire          rd_data  = RD & (ADDR == `SPR_OFS_DATA);
    wire          m_start  = en & master & (st_q == ST_IDLE) & tx_full_q & buf_ready;
    wire          s_reload = (sel_fall | (last & ~cpha)) | (lh_on_q & (lh_q == 3'h0));
    wire          take_tx  = m_start | (slave_on & s_reload);
    wire [DW-1:0] next_tx  = tx_full_q ? tx_q : {DW{1'b0}};
    wire          push     = last;

    spr_buf2 #(
        .W(DW)
    ) u_rxbuf (
        .clk       (SYS_CLK),
        .rst_n     (RST_N),
        .ce        (CE),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .in_data   (rx_nx),
        .out_valid (rx_valid),
        .out_ready (rd_data),
        .out_data  (rx_data)
    );

    // pins from the far side pass two flops before any logic reads them
    always @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            s1_q    <= 4'h2;
            s2_q    <= 4'h2;
            sck_d_q <= 1'b0;
            sel_d_q <= 1'b1;
        end
        else if (CE)
        begin
            s1_q    <= {MISO_I, MOSI_I, SEL_N_I, SCK_I};   // [RULE_11]
            s2_q    <= s1_q;                               // [RULE_11]
            sck_d_q <= sck_s;
            sel_d_q <= sel_n_s;
        end
    end

    // register file
    always @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            div_q     <= `SPR_DIVIDER_RESET;
            ctl_q     <= `SPR_CONTROL_RESET;
            tx_q      <= {DW{1'b0}};
            tx_full_q <= 1'b0;
            ovr_q     <= 1'b0;
            RDATA     <= 8'h00;
        end
        else if (CE)
        begin
            if (WR && ADDR == `SPR_OFS_DIVIDER)
                div_q <= WDATA;
            else if (WR && ADDR == `SPR_OFS_CONTROL)
                ctl_q <= WDATA[3:0];
            if (WR && ADDR == `SPR_OFS_DATA)
            begin
                tx_q      <= WDATA;
                tx_full_q <= 1'b1;
            end
            else if (take_tx)
                tx_full_q <= 1'b0;
            // a new overrun wins over a clear in the same cycle
            if (slave_on && push && !buf_ready)
                ovr_q <= 1'b1;
            else if (WR && ADDR == `SPR_OFS_STATUS && WDATA[`SPR_STS_OVERRUN])
                ovr_q <= 1'b0;
            if (!RD)
                RDATA <= 8'h00;
            else if (ADDR == `SPR_OFS_DIVIDER)
                RDATA <= div_q;
            else if (ADDR == `SPR_OFS_CONTROL)
                RDATA <= {4'h0, ctl_q};
            else if (ADDR == `SPR_OFS_DATA)
                RDATA <= rx_valid ? rx_data : 8'h00;
            else
                RDATA <= {4'h0, ovr_q, tx_full_q, (st_q == ST_RUN), rx_valid};
        end
    end

    // shift engine shared by master and slave
    always @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            st_q    <= ST_IDLE;
            hc_q    <= 8'h00;
            ec_q    <= 4'h0;
            sh_q    <= {DW{1'b0}};
            rx_q    <= {DW{1'b0}};
            lh_q    <= 3'h0;
            lh_on_q <= 1'b0;
            SCK_O   <= 1'b0;
            SCK_OE  <= 1'b0;
            MOSI_O  <= 1'b0;
            MOSI_OE <= 1'b0;
            MISO_O  <= 1'b0;
            MISO_OE <= 1'b0;
        end
        else if (CE)
        begin
            SCK_OE  <= en & master;
            MOSI_OE <= en & master;
            MISO_OE <= slave_on & ~sel_n_s;                // [RULE_05] [RULE_06]
            rx_q    <= rx_nx;
            case (st_q)
                ST_IDLE:
                begin
                    SCK_O <= cpol;                         // [RULE_02]
                    hc_q  <= 8'h00;
                    if (m_start)
                    begin
                        st_q   <= ST_RUN;
                        ec_q   <= 4'h0;
                        MOSI_O <= tx_q[DW-1];
                        sh_q   <= cpha ? tx_q : {tx_q[DW-2:0], 1'b0};
                    end
                    else if (slave_on)
                    begin
                        if (sel_n_s)
                        begin
                            ec_q    <= 4'h0;
                            lh_on_q <= 1'b0;
                        end
                        else if (edge_now)
                            ec_q <= ec_q + 4'h1;
                        if (s_reload)
                        begin
                            lh_on_q <= 1'b0;
                            MISO_O  <= next_tx[DW-1];     // [RULE_05] [RULE_10]
                            sh_q    <= cpha ? next_tx : {next_tx[DW-2:0], 1'b0};
                        end
                        else if (shift)
                        begin
                            MISO_O <= sh_q[DW-1];         // [RULE_09]
                            sh_q   <= {sh_q[DW-2:0], 1'b0};
                        end
                        // phase one holds the last bit a fixed while after the final edge
                        if (last && cpha)
                        begin
                            lh_on_q <= 1'b1;
                            lh_q    <= LAST_WAIT;         // [RULE_10]
                        end
                        else if (lh_on_q && lh_q != 3'h0)
                            lh_q <= lh_q - 3'h1;
                    end
                end
                default:
                begin
                    if (!en || !master)
                        st_q <= ST_IDLE;
                    else if (m_tick)
                    begin
                        hc_q  <= 8'h00;
                        SCK_O <= ~SCK_O;                   // [RULE_01] [RULE_02]
                        ec_q  <= ec_q + 4'h1;
                        if (shift)
                        begin
                            MOSI_O <= sh_q[DW-1];
                            sh_q   <= {sh_q[DW-2:0], 1'b0};
                        end
                        if (last)
                            st_q <= ST_IDLE;
                    end
                    else
                        hc_q <= hc_q + 8'h01;              // [RULE_01]
                end
            endcase
        end
    end

endmodule // spr_core

`default_nettype wire

//--- hw/spr_map.vh
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef SPR_MAP_VH
`define SPR_MAP_VH

`define SPR_ADDR_W          2
`define SPR_OFS_DIVIDER     2'h0
`define SPR_OFS_CONTROL     2'h1
`define SPR_OFS_DATA        2'h2
`define SPR_OFS_STATUS      2'h3

`define SPR_CTL_ENABLE      0
`define SPR_CTL_MASTER      1
`define SPR_CTL_POLARITY    2
`define SPR_CTL_PHASE       3

`define SPR_STS_RX_VALID    0
`define SPR_STS_BUSY        1
`define SPR_STS_TX_FULL     2
`define SPR_STS_OVERRUN     3

`define SPR_DIVIDER_RESET   8'h00
`define SPR_CONTROL_RESET   4'h0

`define SPR_LAST_EDGE       4'hf

`define SPR_CLK_PERIOD_NS   100
`define SPR_LAST_HOLD_NS    600
`define SPR_LAST_HOLD_CYC   ((`SPR_LAST_HOLD_NS + `SPR_CLK_PERIOD_NS - 1) / `SPR_CLK_PERIOD_NS)
// sync and edge detect already use three of the hold cycles
`define SPR_LAST_WAIT       3'h3

`endif

//--- tb/spr_core_chk.sv
// concurrent checks on the serial port pins and master clock rate
`timescale 1ns/1ns
`default_nettype none
`include "spr_map.vh"
module spr_chk (
    input wire                   SYS_CLK,
    input wire                   RST_N,
    input wire                   CE,
    input wire [`SPR_ADDR_W-1:0] ADDR,
    input wire [7:0]             WDATA,
    input wire                   WR,
    input wire                   SCK_I,
    input wire                   SCK_O,
    input wire                   SCK_OE,
    input wire                   MISO_O,
    input wire                   MISO_OE,
    input wire                   SEL_N_I
);
    reg  [7:0] div_q;
    reg  [3:0] ctl_q;
    reg        sck_q;
    reg        sco_q;
    reg  [3:0] since_q;
    reg  [3:0] edges_q;
    reg  [8:0] tog_q;
    wire       edge_w = SCK_I != sck_q;
    wire       last_w = edge_w && edges_q == 4'hf && ctl_q[3] && !ctl_q[1];
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // register copies let the checker know rate and mode without internal taps
    always @(posedge SYS_CLK)
    begin
        sck_q <= SCK_I;
        sco_q <= SCK_O;
        if (!RST_N)
        begin
            div_q   <= `SPR_DIVIDER_RESET;
            ctl_q   <= `SPR_CONTROL_RESET;
            since_q <= 4'hf;
            tog_q   <= 9'h1ff;
            edges_q <= 4'h0;
        end
        else
        begin
            since_q <= edge_w ? 4'h1 : since_q + {3'h0, since_q != 4'hf};
            tog_q   <= (SCK_O != sco_q) ? 9'h1 : tog_q + {8'h0, tog_q != 9'h1ff};
            edges_q <= SEL_N_I ? 4'h0 : edges_q + {3'h0, edge_w};
            if (WR && CE && ADDR == `SPR_OFS_DIVIDER)
                div_q <= WDATA;
            if (WR && CE && ADDR == `SPR_OFS_CONTROL)
                ctl_q <= WDATA[3:0];
        end
    end
    property p_rate;
        SCK_O != sco_q && SCK_OE && $past(SCK_OE) |-> tog_q > {1'b0, div_q};
    endproperty
    a_rate: assert property (p_rate) else $error("clock phase too short");
    property p_idle;
        $rose(SCK_OE) |-> SCK_O == ctl_q[`SPR_CTL_POLARITY];
    endproperty
    a_idle: assert property (p_idle) else $error("clock idle level wrong");
    property p_sel_on;
        $fell(SEL_N_I) && ctl_q[1:0] == 2'h1 |-> ##[1:4] MISO_OE;
    endproperty
    a_sel_on: assert property (p_sel_on) else $error("output late after select");
    property p_sel_off;
        $rose(SEL_N_I) |-> ##[1:4] !MISO_OE;
    endproperty
    a_sel_off: assert property (p_sel_off) else $error("output not released");
    property p_shift;
        $changed(MISO_O) && MISO_OE && $past(MISO_OE)
            |-> since_q <= 4'h4 || (since_q >= 4'h6 && since_q <= 4'h8);
    endproperty
    a_shift: assert property (p_shift) else $error("output change off edge");
    property p_last;
        last_w |-> ##1 $stable(MISO_O)[*5] ##[1:3] $changed(MISO_O);
    endproperty
    a_last: assert property (p_last) else $error("final edge change window");
    property p_sync;
        $fell(SEL_N_I) && !MISO_OE |=> !MISO_OE;
    endproperty
    a_sync: assert property (p_sync) else $error("select not synchronised");
endmodule // spr_chk

bind spr_core spr_chk u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .SCK_I(SCK_I), .SCK_O(SCK_O), .SCK_OE(SCK_OE),
    .MISO_O(MISO_O), .MISO_OE(MISO_OE), .SEL_N_I(SEL_N_I));
`default_nettype wire

//--- tb/spr_peer.sv
// external serial master driving the port in slave mode
`timescale 1ns/1ns
`default_nettype none
module spr_peer (
    input  wire clk,
    input  wire miso,
    output reg  sck,
    output reg  sel_n,
    output reg  mosi
);
    // five clocks per phase: an 800 ns link period would break the minimum
    localparam integer HALF = 5;
    initial
    begin
        sck = 1'b0;
        sel_n = 1'b1;
        mosi = 1'b0;
    end
    task automatic xfer(input pol, input pha, input [7:0] tx, output [7:0] rx);
        integer i;
        begin
            sck <= pol;
            @(posedge clk);
            sel_n <= 1'b0;
            repeat (3) @(posedge clk);
            for (i = 7; i >= 0; i = i - 1)
            begin
                if (pha)
                    sck <= ~pol;
                mosi <= tx[i];
                repeat (HALF) @(posedge clk);
                sck <= pha ? pol : ~pol;
                rx[i] = miso;
                repeat (HALF) @(posedge clk);
                if (!pha)
                    sck <= pol;
            end
            repeat (5) @(posedge clk);
            sel_n <= 1'b1;
            mosi <= ~mosi;
        end
    endtask
endmodule // spr_peer
`default_nettype wire

//--- tb/tb.sv
// register, master rate and slave transfer tests of the serial port
`timescale 1ns/1ns
`default_nettype none
`include "spr_map.vh"
`define CHK(n, e, a) begin checked = checked + 1; if ((a) !== (e)) begin errors = errors + 1; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb;
    reg        clk = 1'b0;
    reg        rst_n = 1'b0;
    reg        wr = 1'b0;
    reg        rd = 1'b0;
    reg  [1:0] addr = 2'h0;
    reg  [7:0] wdata = 8'h00;
    reg        miso_i = 1'b0;
    reg        hold = 1'b0;
    reg        ce = 1'b1;
    wire [7:0] rdata;
    wire       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, sck_i, sel_n, mosi_i;
    wire       miso_w = miso_oe ? miso_o : ~hold;
    integer    errors = 0, checked = 0, d, n, k;
    reg  [7:0] v, r;
    initial
        forever #50 clk = ~clk;
    spr_core uut (.SYS_CLK(clk), .RST_N(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .SCK_I(sck_i), .SCK_O(sck_o), .SCK_OE(sck_oe),
        .MOSI_I(mosi_i), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso_i),
        .MISO_O(miso_o), .MISO_OE(miso_oe), .SEL_N_I(sel_n));
    spr_peer u_peer (.clk(clk), .miso(miso_w), .sck(sck_i), .sel_n(sel_n), .mosi(mosi_i));
    // released line shows the inverse of its last driven level; master far side echoes
    always @(posedge clk)
    begin
        miso_i <= mosi_o;
        if (miso_oe)
            hold <= miso_o;
    end
    task wreg(input [1:0] a, input [7:0] x);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= x;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rreg(input [1:0] a, output [7:0] x);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 x = rdata;
        end
    endtask
    task summarize;
        begin
            $display("errors %0d checked %0d", errors, checked);
            if (errors == 0 && checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial
    begin
        #3000000;
        errors = errors + 1;
        summarize;
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rreg(`SPR_OFS_DIVIDER, r);
        `CHK("div reset", 8'h00, r)
        wreg(`SPR_OFS_DIVIDER, 8'ha5);
        rreg(`SPR_OFS_DIVIDER, r);
        `CHK("div rw", 8'ha5, r)
        @(posedge clk);
        #1 `CHK("rdata idle", 8'h00, rdata)
        @(posedge clk);
        ce <= 1'b0;
        wreg(`SPR_OFS_DIVIDER, 8'h3c);
        ce <= 1'b1;
        rreg(`SPR_OFS_DIVIDER, r);
        `CHK("frozen", 8'ha5, r)
        for (k = 0; k < 6; k = k + 1)
        begin
            d = k < 2 ? 0 : (k < 4 ? 4 : 255);
            wreg(`SPR_OFS_CONTROL, 8'h00);
            wreg(`SPR_OFS_DIVIDER, d[7:0]);
            wreg(`SPR_OFS_CONTROL, {4'h0, k[1], k[0], 2'h3});
            wreg(`SPR_OFS_DATA, 8'h5a + k[7:0]);
            #1 `CHK("idle", k[0], sck_o)
            `CHK("drive", 2'h3, {sck_oe, mosi_oe})
            n = 0;
            while (sck_o === k[0] && n < 300)
            begin
                @(posedge clk);
                n = n + 1;
            end
            n = 0;
            while (sck_o !== k[0] && n < 300)
            begin
                @(posedge clk);
                n = n + 1;
            end
            `CHK("half period", d + 1, n)
            r = 8'h02;
            for (n = 0; n < 3000 && r[`SPR_STS_BUSY] !== 1'b0; n = n + 1)
                rreg(`SPR_OFS_STATUS, r);
            `CHK("busy", 1'b0, r[`SPR_STS_BUSY])
            rreg(`SPR_OFS_DATA, r);
            if (d != 0)
                `CHK("echo", 8'h5a + k[7:0], r)
        end
        for (k = 0; k < 4; k = k + 1)
        begin
            wreg(`SPR_OFS_CONTROL, 8'h00);
            wreg(`SPR_OFS_CONTROL, {4'h0, k[1], k[0], 2'h1});
            wreg(`SPR_OFS_DATA, 8'h3b);
            u_peer.xfer(k[0], k[1], 8'hc6 ^ k[7:0], v);
            `CHK("slave out", 8'h3b, v)
            repeat (5) @(posedge clk);
            #1 `CHK("released", 1'b0, miso_oe)
            `CHK("no drive", 2'h0, {sck_oe, mosi_oe})
            rreg(`SPR_OFS_DATA, r);
            `CHK("slave in", 8'hc6 ^ k[7:0], r)
        end
        wreg(`SPR_OFS_CONTROL, 8'h01);
        for (k = 1; k < 4; k = k + 1)
            u_peer.xfer(1'b0, 1'b0, 8'h10 + k[7:0], v);
        rreg(`SPR_OFS_STATUS, r);
        `CHK("full", 8'h09, r)
        for (k = 1; k < 4; k = k + 1)
        begin
            rreg(`SPR_OFS_DATA, r);
            `CHK("drain", k < 3 ? 8'h10 + k[7:0] : 8'h00, r)
        end
        wreg(`SPR_OFS_STATUS, 8'h08);
        rreg(`SPR_OFS_STATUS, r);
        `CHK("empty", 8'h00, r)
        summarize;
    end
endmodule // tb
`default_nettype wire
